// *** design/mfp_consts.vh ***
// constants of the fault reporting and address space protection block
`ifndef MFP_CONSTS_VH
`define MFP_CONSTS_VH
`define MFP_OFF_TC     8'h00
`define MFP_OFF_CRP    8'h04
`define MFP_OFF_SRP    8'h08
`define MFP_OFF_DRP    8'h0C
`define MFP_OFF_DATA   8'h10
`define MFP_OFF_CMD    8'h14
`define MFP_OFF_EXC    8'h18
`define MFP_OFF_ISTAT  8'h1C
`define MFP_OFF_IMASK  8'h20
`define MFP_OFF_TRES   8'h24
`define MFP_TC_E       0
`define MFP_TC_SRE     1
`define MFP_TC_FCL     2
`define MFP_TC_LVL_HI  5
`define MFP_TC_LVL_LO  3
`define MFP_TC_RSV_LO  6
`define MFP_VEC_FLINE  8'h0B
`define MFP_VEC_PROTO  8'h0D
`define MFP_VEC_CFG    8'h38
`define MFP_VEC_ILLOP  8'h39
`define MFP_VEC_ACCV   8'h3A
`define MFP_OP_TEST    4'h1
`define MFP_OP_LOAD    4'h2
`define MFP_OP_VALID   4'h3
`define MFP_OP_SAVE    4'h4
`define MFP_OP_RET     4'h5
`define MFP_OP_TC      4'h8
`define MFP_OP_CRP     4'h9
`define MFP_OP_SRP     4'hA
`define MFP_OP_DRP     4'hB
`define MFP_ROOT_CRP   2'h0
`define MFP_ROOT_SRP   2'h1
`define MFP_INT_EXC    0
`define MFP_INT_BUS_ERROR_SIGNAL   1
`define MFP_INT_WALK   2
`define MFP_RST_WORD   32'h0000_0000
`define MFP_RST_INT    3'h0
`define MFP_RST_VEC    8'h00
`endif

// *** design/mfp_sync.v ***
// two-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/10ps
`default_nettype none
module mfp_sync #(
	parameter W = 15
) (
	input  wire         clk,
	input  wire         rst_n,
	input  wire [W-1:0] d,
	output wire [W-1:0] q
);
	genvar g;
	generate
		for (g = 0; g < W; g = g + 1) begin : g_bit
			reg meta_q;
			reg sync_q;
			always @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					meta_q <= 1'b0;
					sync_q <= 1'b0;
				end else begin
					meta_q <= d[g];
					sync_q <= meta_q;
				end
			end
			assign q[g] = sync_q;
		end
	endgenerate
endmodule
`default_nettype wire

// *** design/mfp_root_sel.v ***
// translation table root and function code level selection
`timescale 1ns/10ps
`default_nettype none
`include "mfp_consts.vh"
module mfp_root_sel (
	input  wire [2:0] function_code_lines,
	input  wire       supervisor_root_enable,
	input  wire       function_code_lookup_enable,
	output wire [1:0] root,
	output wire       fc_level
);
	// fc bit two marks a supervisor reference
	assign root = (supervisor_root_enable && function_code_lines[2]) ? `MFP_ROOT_SRP : `MFP_ROOT_CRP;
	// with the level skipped the walker ignores the fc index
	assign fc_level = function_code_lookup_enable;
endmodule
`default_nettype wire

// *** design/mfp_top.v ***
// fault reporting and address space protection block with apb registers
`timescale 1ns/10ps
`default_nettype none
`include "mfp_consts.vh"
module mfp_top (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire        la_req,
	input  wire [2:0]  function_code_lines,
	input  wire [7:0]  la_page,
	output wire        phys_as,
	output wire        bus_error_signal,
	output wire        walk_req,
	output wire [1:0]  walk_root,
	output wire        walk_fc_level,
	output wire [2:0]  walk_fc,
	output wire [7:0]  walk_page,
	input  wire        walk_done,
	input  wire        walk_sbit,
	input  wire        walk_invalid,
	output wire        cp_take_exc,
	output wire [7:0]  cp_vector,
	output wire        cp_post,
	output wire        irq
);
	// ----------------------------------------
	// local definitions
	// ----------------------------------------
	localparam ST_IDLE = 2'b00;
	localparam ST_LOOK = 2'b01;
	localparam ST_WALK = 2'b10;
	localparam ST_REL  = 2'b11;

	function reg_hit;
		input [7:0] a;
		begin
			case (a)
				`MFP_OFF_TC, `MFP_OFF_CRP, `MFP_OFF_SRP, `MFP_OFF_DRP,
				`MFP_OFF_DATA, `MFP_OFF_CMD, `MFP_OFF_EXC, `MFP_OFF_ISTAT,
				`MFP_OFF_IMASK, `MFP_OFF_TRES: reg_hit = 1'b1;
				default: reg_hit = 1'b0;
			endcase
		end
	endfunction

	function is_cfg;
		input [7:0] a;
		begin
			is_cfg = (a == `MFP_OFF_TC) || (a == `MFP_OFF_CRP) ||
				(a == `MFP_OFF_SRP) || (a == `MFP_OFF_DRP);
		end
	endfunction

	function [3:0] cfg_op;
		input [7:0] a;
		begin
			case (a)
				`MFP_OFF_TC:  cfg_op = `MFP_OP_TC;
				`MFP_OFF_CRP: cfg_op = `MFP_OP_CRP;
				`MFP_OFF_SRP: cfg_op = `MFP_OP_SRP;
				default:      cfg_op = `MFP_OP_DRP;
			endcase
		end
	endfunction

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	// page and fc are held by the master while la_req is up,
	// so a bit skew between them settles before the lookup
	wire [14:0] sync_s;
	mfp_sync #(
		.W(15)
	) u_sync (
		.clk   (pclk),
		.rst_n (presetn),
		.d     ({la_req, function_code_lines, la_page, walk_done, walk_sbit, walk_invalid}),
		.q     (sync_s)
	);
	wire       la_req_s  = sync_s[14];
	wire [2:0] fc_s      = sync_s[13:11];
	wire [7:0] page_s    = sync_s[10:3];
	wire       done_s    = sync_s[2];
	wire       sbit_s    = sync_s[1];
	wire       inval_s   = sync_s[0];

	// ----------------------------------------
	// registers
	// ----------------------------------------
	reg        pready_q;
	reg        pslverr_q;
	reg [31:0] prdata_q;
	reg [31:0] tc_q;
	reg [31:0] crp_q;
	reg [31:0] srp_q;
	reg [31:0] drp_q;
	reg [31:0] data_q;
	reg        exc_take_q;
	reg [7:0]  exc_vec_q;
	reg        exc_post_q;
	reg        defer_v_q;
	reg [3:0]  defer_op_q;
	reg [31:0] defer_data_q;
	reg [2:0]  istat_q;
	reg [2:0]  imask_q;
	reg        irq_q;
	reg [2:0]  tres_q;
	reg [1:0]  st_q;
	reg        src_cmd_q;
	reg        src_load_q;
	reg [2:0]  acc_fc_q;
	reg [7:0]  acc_page_q;
	reg        pas_q;
	reg        bus_error_signal_q;
	reg        walk_req_q;
	reg [1:0]  walk_root_q;
	reg        walk_fcl_q;
	reg        done_d_q;
	reg        c_v     [0:7];
	reg [4:0]  c_tag   [0:7];
	reg [2:0]  c_fc    [0:7];
	reg        c_sup   [0:7];
	reg        c_bus_error_signal  [0:7];

	// ----------------------------------------
	// apb slave
	// ----------------------------------------
	// one wait state so that every bus output leaves a flip-flop
	wire acc   = psel & penable & pready_q;
	wire wr    = acc & pwrite;
	wire rd_ck = acc & ~pwrite & (paddr == `MFP_OFF_ISTAT);
	reg [31:0] rd_word;

	always @* begin
		case (paddr)
			`MFP_OFF_TC:    rd_word = tc_q;
			`MFP_OFF_CRP:   rd_word = crp_q;
			`MFP_OFF_SRP:   rd_word = srp_q;
			`MFP_OFF_DRP:   rd_word = drp_q;
			`MFP_OFF_DATA:  rd_word = data_q;
			`MFP_OFF_EXC:   rd_word = {21'h0, defer_v_q, exc_post_q, exc_take_q, exc_vec_q};
			`MFP_OFF_ISTAT: rd_word = {29'h0, istat_q};
			`MFP_OFF_IMASK: rd_word = {29'h0, imask_q};
			`MFP_OFF_TRES:  rd_word = {29'h0, tres_q};
			default:        rd_word = `MFP_RST_WORD;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= `MFP_RST_WORD;
		end else begin
			pready_q  <= psel & penable & ~pready_q;
			pslverr_q <= psel & penable & ~pready_q & ~reg_hit(paddr);
			prdata_q  <= (psel & penable & ~pready_q & ~pwrite) ? rd_word : `MFP_RST_WORD;
		end
	end

	// ----------------------------------------
	// instruction execution and exceptions
	// ----------------------------------------
	wire        new_ins  = wr & (is_cfg(paddr) | (paddr == `MFP_OFF_CMD));
	wire [3:0]  new_op   = is_cfg(paddr) ? cfg_op(paddr) : pwdata[3:0];
	wire [31:0] new_data = is_cfg(paddr) ? pwdata : data_q;
	wire        busy     = (st_q != ST_IDLE);
	reg         x_go;
	reg [3:0]   x_op;
	reg [31:0]  x_data;
	reg         viol;
	reg         ret;
	reg         raise;
	reg [7:0]   rvec;
	reg         rpost;
	reg         start_cmd;
	reg         flush;

	always @* begin
		x_go = 1'b0;
		x_op = new_op;
		x_data = new_data;
		viol = 1'b0;
		ret = 1'b0;
		if (new_ins) begin
			if (new_op == `MFP_OP_RET) begin
				ret = 1'b1;
				// retry what was presented during the fault
				if (exc_take_q && defer_v_q) begin
					x_go = 1'b1;
					x_op = defer_op_q;
					x_data = defer_data_q;
				end
			end else if (new_op != `MFP_OP_SAVE) begin
				// only a context save or a return may run while a fault is outstanding
				if (exc_take_q)
					viol = 1'b1;
				else
					x_go = 1'b1;
			end
		end
	end

	always @* begin
		raise = viol;
		rvec = `MFP_VEC_PROTO;
		rpost = 1'b0;
		start_cmd = 1'b0;
		flush = 1'b0;
		if (x_go) begin
			case (x_op)
				`MFP_OP_TC: begin
					raise = (x_data[31:`MFP_TC_RSV_LO] != 26'h0);
					flush = ~raise;
				end
				`MFP_OP_CRP, `MFP_OP_SRP, `MFP_OP_DRP: begin
					// descriptor type zero marks an invalid root
					raise = (x_data[1:0] == 2'h0);
					flush = ~raise;
				end
				`MFP_OP_TEST, `MFP_OP_LOAD: begin
					raise = ~tc_q[`MFP_TC_E] | busy;
					start_cmd = ~raise;
				end
				`MFP_OP_VALID: begin
					raise = (x_data[2:0] > tc_q[`MFP_TC_LVL_HI:`MFP_TC_LVL_LO]);
				end
				default: begin
					raise = 1'b1;
				end
			endcase
			case (x_op)
				`MFP_OP_TC, `MFP_OP_CRP, `MFP_OP_SRP, `MFP_OP_DRP: begin
					rvec = `MFP_VEC_CFG;
					rpost = 1'b1;
				end
				`MFP_OP_TEST, `MFP_OP_LOAD: begin
					rvec = busy ? `MFP_VEC_PROTO : `MFP_VEC_ILLOP;
					rpost = ~busy;
				end
				`MFP_OP_VALID: begin
					rvec = `MFP_VEC_ACCV;
					rpost = 1'b1;
				end
				default: begin
					rvec = `MFP_VEC_FLINE;
					rpost = 1'b0;
				end
			endcase
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tc_q         <= `MFP_RST_WORD;
			crp_q        <= `MFP_RST_WORD;
			srp_q        <= `MFP_RST_WORD;
			drp_q        <= `MFP_RST_WORD;
			data_q       <= `MFP_RST_WORD;
			exc_take_q   <= 1'b0;
			exc_vec_q    <= `MFP_RST_VEC;
			exc_post_q   <= 1'b0;
			defer_v_q    <= 1'b0;
			defer_op_q   <= 4'h0;
			defer_data_q <= `MFP_RST_WORD;
		end else begin
			if (wr && paddr == `MFP_OFF_DATA)
				data_q <= pwdata;
			if (flush) begin
				case (x_op)
					`MFP_OP_TC:  tc_q <= x_data;
					`MFP_OP_CRP: crp_q <= x_data;
					`MFP_OP_SRP: srp_q <= x_data;
					default:     drp_q <= x_data;
				endcase
			end
			// post class tells the processor to step its scan counter first
			if (raise) begin
				exc_take_q <= 1'b1;
				exc_vec_q  <= rvec;
				exc_post_q <= rpost;
			end else if (ret) begin
				exc_take_q <= 1'b0;
			end
			// the earlier faulted instruction is dropped, the newer kept
			if (viol) begin
				defer_v_q    <= 1'b1;
				defer_op_q   <= new_op;
				defer_data_q <= new_data;
			end else if (ret || raise) begin
				defer_v_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// lookup, table walk and translation cache
	// ----------------------------------------
	wire [2:0] sel_fc = (st_q == ST_IDLE) ? x_data[10:8] : acc_fc_q;
	wire [1:0] sel_root;
	wire       sel_fcl;
	mfp_root_sel u_root (
		.function_code_lines         (sel_fc),
		.supervisor_root_enable      (tc_q[`MFP_TC_SRE]),
		.function_code_lookup_enable (tc_q[`MFP_TC_FCL]),
		.root                        (sel_root),
		.fc_level                    (sel_fcl)
	);

	wire [2:0] idx       = acc_page_q[2:0];
	wire       hit       = c_v[idx] && (c_tag[idx] == acc_page_q[7:3]) && (c_fc[idx] == acc_fc_q);
	wire       hit_bad   = c_bus_error_signal[idx] | (c_sup[idx] & ~acc_fc_q[2]);
	wire       done_rise = done_s & ~done_d_q;
	wire       ev_bus_error_signal   = (st_q == ST_LOOK) & tc_q[`MFP_TC_E] & hit & hit_bad;
	wire       ev_walk   = (st_q == ST_WALK) & done_rise;
	integer i;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q        <= ST_IDLE;
			src_cmd_q   <= 1'b0;
			src_load_q  <= 1'b0;
			acc_fc_q    <= 3'h0;
			acc_page_q  <= 8'h00;
			pas_q       <= 1'b0;
			bus_error_signal_q      <= 1'b0;
			walk_req_q  <= 1'b0;
			walk_root_q <= `MFP_ROOT_CRP;
			walk_fcl_q  <= 1'b0;
			done_d_q    <= 1'b0;
			tres_q      <= 3'h0;
			for (i = 0; i < 8; i = i + 1) begin
				c_v[i]    <= 1'b0;
				c_tag[i]  <= 5'h00;
				c_fc[i]   <= 3'h0;
				c_sup[i]  <= 1'b0;
				c_bus_error_signal[i] <= 1'b0;
			end
		end else begin
			done_d_q <= done_s;
			pas_q    <= 1'b0;
			bus_error_signal_q   <= 1'b0;
			// a new mapping makes every cached entry stale
			if (flush) begin
				for (i = 0; i < 8; i = i + 1)
					c_v[i] <= 1'b0;
			end
			case (st_q)
				ST_IDLE: begin
					if (start_cmd) begin
						src_cmd_q   <= 1'b1;
						src_load_q  <= (x_op == `MFP_OP_LOAD);
						acc_fc_q    <= x_data[10:8];
						acc_page_q  <= x_data[7:0];
						walk_req_q  <= 1'b1;
						walk_root_q <= sel_root;
						walk_fcl_q  <= sel_fcl;
						st_q        <= ST_WALK;
					end else if (la_req_s) begin
						src_cmd_q  <= 1'b0;
						src_load_q <= 1'b1;
						acc_fc_q   <= fc_s;
						acc_page_q <= page_s;
						st_q       <= ST_LOOK;
					end
				end
				ST_LOOK: begin
					if (!tc_q[`MFP_TC_E]) begin
						pas_q <= 1'b1;
						st_q  <= ST_REL;
					end else if (hit) begin
						// strobe only through a mapping that allows the access
						pas_q  <= ~hit_bad;
						bus_error_signal_q <= hit_bad;
						st_q   <= ST_REL;
					end else begin
						walk_req_q  <= 1'b1;
						walk_root_q <= sel_root;
						walk_fcl_q  <= sel_fcl;
						st_q        <= ST_WALK;
					end
				end
				ST_WALK: begin
					if (done_rise) begin
						walk_req_q <= 1'b0;
						if (src_load_q) begin
							c_v[idx]    <= 1'b1;
							c_tag[idx]  <= acc_page_q[7:3];
							c_fc[idx]   <= acc_fc_q;
							c_sup[idx]  <= sbit_s;
							c_bus_error_signal[idx] <= inval_s | (sbit_s & ~acc_fc_q[2]);
						end
						if (src_cmd_q) begin
							tres_q <= {1'b1, sbit_s & ~acc_fc_q[2], inval_s};
							st_q   <= ST_IDLE;
						end else begin
							// bus access retries against the fresh entry
							st_q <= ST_LOOK;
						end
					end
				end
				ST_REL: begin
					if (!la_req_s)
						st_q <= ST_IDLE;
				end
				default: begin
					st_q <= ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// interrupt status and mask
	// ----------------------------------------
	// only bits already returned are cleared, so a late event survives
	wire [2:0] iset  = {ev_walk, ev_bus_error_signal, raise};
	wire [2:0] iclr  = rd_ck ? prdata_q[2:0] : 3'h0;
	wire [2:0] istat_d = (istat_q & ~iclr) | iset;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			istat_q <= `MFP_RST_INT;
			imask_q <= `MFP_RST_INT;
			irq_q   <= 1'b0;
		end else begin
			istat_q <= istat_d;
			if (wr && paddr == `MFP_OFF_IMASK)
				imask_q <= pwdata[2:0];
			irq_q <= |(istat_d & imask_q);
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign prdata           = prdata_q;
	assign pready           = pready_q;
	assign pslverr          = pslverr_q;
	assign phys_as          = pas_q;
	assign bus_error_signal = bus_error_signal_q;
	assign walk_req         = walk_req_q;
	assign walk_root        = walk_root_q;
	assign walk_fc_level    = walk_fcl_q;
	assign walk_fc          = acc_fc_q;
	assign walk_page        = acc_page_q;
	assign cp_take_exc      = exc_take_q;
	assign cp_vector        = exc_vec_q;
	assign cp_post          = exc_post_q;
	assign irq              = irq_q;
endmodule
`default_nettype wire

// *** tb/mfp_top_sva.sv ***
// assertions for the fault reporting and protection block
`timescale 1ns/10ps
`default_nettype none
`include "mfp_consts.vh"
module mfp_top_sva (
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pready,
	input wire logic       pslverr,
	input wire logic       la_req,
	input wire logic       phys_as,
	input wire logic       bus_error_signal,
	input wire logic       walk_req,
	input wire logic [1:0] walk_root,
	input wire logic [2:0] walk_fc,
	input wire logic       walk_done,
	input wire logic       walk_sbit,
	input wire logic       walk_invalid,
	input wire logic       cp_take_exc,
	input wire logic [7:0] cp_vector,
	input wire logic       cp_post
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ----
	// walk completion steps
	// ----
	sequence s_walk_end;
		la_req && walk_req && $rose(walk_done);
	endsequence
	sequence s_bad_end;
		s_walk_end ##0 (walk_invalid || (walk_sbit && !walk_fc[2]));
	endsequence
	sequence s_good_end;
		s_walk_end ##0 (!walk_invalid && !(walk_sbit && !walk_fc[2]));
	endsequence
	a_pready_wait: assert property (psel && penable && !pready |=> pready)
		else $error("pready not one cycle after access start");
	a_pready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_slverr_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_pre_class: assert property (cp_take_exc && cp_vector inside {`MFP_VEC_FLINE, `MFP_VEC_PROTO} |-> !cp_post)
		else $error("pre exception flagged post");
	a_post_class: assert property (cp_take_exc && cp_vector inside {`MFP_VEC_CFG, `MFP_VEC_ILLOP, `MFP_VEC_ACCV} |-> cp_post)
		else $error("post exception flagged pre");
	a_strobe_only: assert property (phys_as |-> la_req && !bus_error_signal ##1 !phys_as)
		else $error("strobe without access or with bus error");
	a_user_root: assert property (walk_req && walk_root == `MFP_ROOT_SRP |-> walk_fc[2])
		else $error("user access walked from supervisor root");
	a_walk_release: assert property (walk_req && $rose(walk_done) |-> ##[1:4] !walk_req)
		else $error("walk request held after done");
	a_bus_error_signal_fill: assert property (s_bad_end |-> ##[2:8] bus_error_signal && !phys_as)
		else $error("faulting walk did not end in bus error");
	a_as_fill: assert property (s_good_end |-> ##[2:8] phys_as)
		else $error("valid walk did not give strobe");
	a_la_answer: assert property ($rose(la_req) |-> ##[3:8] (phys_as || bus_error_signal || walk_req))
		else $error("bus access not answered");
endmodule
bind mfp_top mfp_top_sva u_sva (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .la_req, .phys_as,
	.bus_error_signal, .walk_req, .walk_root, .walk_fc, .walk_done, .walk_sbit, .walk_invalid,
	.cp_take_exc, .cp_vector, .cp_post);
`default_nettype wire

// *** tb/mfp_walk_model.sv ***
// table walker and processor side model
`timescale 1ns/10ps
`default_nettype none
module mfp_walk_model (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       walk_req,
	input  wire logic [7:0] walk_page,
	input  wire logic       cp_take_exc,
	input  wire logic       cp_post,
	output logic            walk_done,
	output logic            walk_sbit,
	output logic            walk_invalid,
	output logic [7:0]      scan_count
);
	logic [2:0] cnt_q;
	logic       busy_q;
	logic       tog_q;
	logic       take_q;
	// result hangs on page only: user and supervisor entries share one branch
	assign walk_sbit    = walk_done ? walk_page[7] : tog_q;
	// lines carry junk outside a result so stale values are never trusted
	assign walk_invalid = walk_done ? walk_page[6] : ~tog_q;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 3'h0;
			busy_q <= 1'b0;
			tog_q <= 1'b0;
			take_q <= 1'b0;
			walk_done <= 1'b0;
			scan_count <= 8'h00;
		end else begin
			tog_q <= ~tog_q;
			take_q <= cp_take_exc;
			if (cp_take_exc && !take_q && cp_post)
				scan_count <= scan_count + 8'h01;
			if (walk_req && !busy_q && !walk_done) begin
				busy_q <= 1'b1;
				cnt_q <= walk_page[0] ? 3'h6 : 3'h1;
			end else if (busy_q && cnt_q != 3'h0)
				cnt_q <= cnt_q - 3'h1;
			else if (busy_q) begin
				busy_q <= 1'b0;
				walk_done <= 1'b1;
			end else if (walk_done && !walk_req)
				walk_done <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// *** tb/mmu_fault_protection_tb.sv ***
// self-checking testbench for the fault reporting and protection block
`timescale 1ns/10ps
`default_nettype none
module mmu_fault_protection_tb;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [7:0] v; logic p;} mfp_row_t;
	typedef struct {logic [31:0] tc; logic [2:0] f; logic [7:0] pg; logic w;} mfp_acc_t;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, la_req = 0;
	logic [7:0]  paddr = 0, la_page = 0, walk_page, cp_vector, scan_count;
	logic [31:0] pwdata = 0, prdata, rd, cur_tc = 0;
	logic [2:0]  function_code_lines = 0, walk_fc;
	logic [1:0]  walk_root, wr;
	logic        pready, pslverr, phys_as, bus_error_signal, walk_req, walk_fc_level;
	logic        walk_done, walk_sbit, walk_invalid, cp_take_exc, cp_post, irq;
	logic        er, as, be, walked, wl, bx;
	int          fail_count = 0, tests_run = 0;
	mfp_row_t rows [9] = '{
		'{8'h14, 32'h0000_0007, 8'h0B, 1'b0}, '{8'h00, 32'h0000_0040, 8'h38, 1'b1},
		'{8'h04, 32'h0000_0000, 8'h38, 1'b1}, '{8'h08, 32'h0000_0100, 8'h38, 1'b1},
		'{8'h0C, 32'h0000_0004, 8'h38, 1'b1}, '{8'h04, 32'h0000_0101, 8'h00, 1'b0},
		'{8'h14, 32'h0000_0001, 8'h39, 1'b1}, '{8'h14, 32'h0000_0002, 8'h39, 1'b1},
		'{8'h14, 32'h0000_0003, 8'h3A, 1'b1}};
	mfp_acc_t accs [7] = '{
		'{32'h0000_0000, 3'h5, 8'h01, 1'b0}, '{32'h0000_0007, 3'h5, 8'h81, 1'b1},
		'{32'h0000_0000, 3'h1, 8'h82, 1'b1}, '{32'h0000_0000, 3'h1, 8'h82, 1'b0},
		'{32'h0000_0000, 3'h2, 8'h43, 1'b1}, '{32'h0000_0000, 3'h1, 8'h04, 1'b1},
		'{32'h0000_0001, 3'h5, 8'h05, 1'b1}};
	mfp_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.la_req, .function_code_lines, .la_page, .phys_as, .bus_error_signal, .walk_req, .walk_root,
		.walk_fc_level, .walk_fc, .walk_page, .walk_done, .walk_sbit, .walk_invalid, .cp_take_exc,
		.cp_vector, .cp_post, .irq);
	mfp_walk_model u_walk (.pclk, .presetn, .walk_req, .walk_page, .cp_take_exc, .cp_post, .walk_done,
		.walk_sbit, .walk_invalid, .scan_count);
	initial forever #10 pclk = ~pclk;
	task chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			$display("BAD %0t got %h exp %h", $time, g, e);
			fail_count++;
		end
	endtask
	task end_sim;
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ----
	// bus cycles
	// ----
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		// no assumed latency: only the watchdog ends a hung transfer
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task cpchk(input logic t, input logic p, input logic [7:0] v);
		repeat (2) @(negedge pclk);
		// vector and class keep the last fault after a return
		if (t)
			chk({cp_take_exc, cp_post, cp_vector}, {t, p, v});
		else
			chk(cp_take_exc, 0);
	endtask
	// one logical access, held until the block answers
	task acc(input logic [2:0] f, input logic [7:0] p);
		int n;
		@(posedge pclk);
		function_code_lines <= f;
		la_page <= p;
		la_req <= 1;
		walked = 0;
		for (n = 0; n < 60 && phys_as !== 1'b1 && bus_error_signal !== 1'b1; n++) begin
			@(posedge pclk);
			if (walk_req === 1'b1) begin
				walked = 1;
				wr = walk_root;
				wl = walk_fc_level;
			end
		end
		as = phys_as;
		be = bus_error_signal;
		la_req <= 0;
		repeat (5) @(posedge pclk);
	endtask
	// ----
	// tests
	// ----
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1;
		@(negedge pclk);
		chk({cp_take_exc, irq, phys_as, bus_error_signal, walk_req, walk_root}, 0);
		apb(0, 8'h18, 0);
		chk(rd, 0);
		apb(0, 8'h30, 0);
		chk({er, rd[30:0]}, 32'h8000_0000);
		apb(1, 8'h10, 32'h0000_0003);
		for (int i = 0; i < 9; i++) begin
			apb(1, rows[i].a, rows[i].d);
			cpchk(rows[i].v != 0, rows[i].p, rows[i].v);
			apb(0, 8'h18, 0);
			if (rows[i].v != 0)
				chk(rd[9:0], {rows[i].p, 1'b1, rows[i].v});
			else
				chk(rd[8], 0);
			apb(1, 8'h14, 32'h0000_0005);
		end
		chk(scan_count, 8'h07);
		$display("exception table done");
		apb(1, 8'h14, 32'h0000_0007);
		apb(1, 8'h14, 32'h0000_0003);
		cpchk(1, 0, 8'h0D);
		apb(1, 8'h14, 32'h0000_0005);
		cpchk(1, 1, 8'h3A);
		apb(1, 8'h14, 32'h0000_0005);
		repeat (2) @(negedge pclk);
		chk(cp_take_exc, 0);
		$display("retry test done");
		apb(0, 8'h1C, 0);
		apb(1, 8'h14, 32'h0000_0007);
		cpchk(1, 0, 8'h0B);
		chk(irq, 0);
		apb(1, 8'h20, 32'h0000_0001);
		repeat (2) @(negedge pclk);
		chk(irq, 1);
		apb(0, 8'h1C, 0);
		chk(rd[0], 1);
		repeat (2) @(negedge pclk);
		chk(irq, 0);
		@(posedge pclk);
		presetn <= 0;
		@(posedge pclk);
		presetn <= 1;
		@(negedge pclk);
		chk({cp_take_exc, irq}, 0);
		$display("interrupt and reset test done");
		apb(1, 8'h04, 32'h0000_0101);
		apb(1, 8'h08, 32'h0000_0201);
		for (int i = 0; i < 7; i++) begin
			if (accs[i].tc != 0) begin
				cur_tc = accs[i].tc;
				apb(1, 8'h00, cur_tc);
			end
			acc(accs[i].f, accs[i].pg);
			bx = cur_tc[0] & (accs[i].pg[6] | (accs[i].pg[7] & ~accs[i].f[2]));
			chk({as, be, walked}, {~bx, bx, accs[i].w});
			if (accs[i].w)
				chk({wr, wl}, {1'b0, cur_tc[1] & accs[i].f[2], cur_tc[2]});
		end
		apb(0, 8'h1C, 0);
		chk(rd[2:0], 3'h6);
		apb(1, 8'h10, 32'h0000_0182);
		apb(1, 8'h14, 32'h0000_0001);
		repeat (12) @(posedge pclk);
		apb(0, 8'h24, 0);
		chk(rd[2:0], 3'h6);
		$display("access table done");
		end_sim;
	end
	// run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge pclk);
		fail_count++;
		end_sim;
	end
endmodule
`default_nettype wire
